/* smdi_map.svh */
// Constants of the modem interface and bit timing recovery block
`ifndef SMDI_MAP_SVH
`define SMDI_MAP_SVH

// ****************************************************************
// Modem port layout
// ****************************************************************
`define SMDI_IN_CTS_BIT 0
`define SMDI_IN_CD_BIT 1
`define SMDI_IN_UNUSED 3'h7
`define SMDI_OUT_RTS_BIT 0
`define SMDI_OUT_UNUSED 2'h0
`define SMDI_OUT_RESET 8'h00

// ****************************************************************
// Completion result codes
// ****************************************************************
`define SMDI_RES_OK 8'h00
`define SMDI_RES_CTS_FAIL 8'h01
`define SMDI_RES_CD_FAIL 8'h02

// ****************************************************************
// Serial framing and timing
// ****************************************************************
`define SMDI_FLAG_CHAR 8'h7E
`define SMDI_BYTE_LAST 3'h7
`define SMDI_BIT_TIMING_RECOVERY_PULSE_NOMINAL 6'h20
`define SMDI_BIT_TIMING_RECOVERY_PULSE_Q1_INT 6'h1E
`define SMDI_BIT_TIMING_RECOVERY_PULSE_Q2_INT 6'h1F
`define SMDI_BIT_TIMING_RECOVERY_PULSE_Q3_INT 6'h21
`define SMDI_BIT_TIMING_RECOVERY_PULSE_Q4_INT 6'h22
`define SMDI_BIT_TIMING_RECOVERY_PULSE_IDLE_ONES 4'hF

`endif

/* smdi_pkg.sv */
// Types shared by the modem interface block
`default_nettype none
package smdi_pkg;

	typedef enum logic [1:0]
	{
		SMDI_OP_RD_IN = 2'h0,
		SMDI_OP_RD_OUT = 2'h1,
		SMDI_OP_WR_OUT = 2'h2,
		SMDI_OP_NONE = 2'h3
	} smdi_port_op_e;

	typedef enum logic [3:0]
	{
		SMDI_TX_IDLE = 4'b0001,
		SMDI_TX_WAIT = 4'b0010,
		SMDI_TX_SEND = 4'b0100,
		SMDI_TX_TAIL = 4'b1000
	} smdi_tx_state_e;

	typedef enum logic [2:0]
	{
		SMDI_RX_OFF = 3'b001,
		SMDI_RX_HUNT = 3'b010,
		SMDI_RX_FRAME = 3'b100
	} smdi_rx_state_e;

endpackage
`default_nettype wire

/* smdi_bit_timing_recovery_pulse.sv */
// Digital bit timing recovery loop on a 32x sample tick
`timescale 1ns/1ps
`default_nettype none
`include "smdi_map.svh"
module smdi_bit_timing_recovery_pulse (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic sample_tick,
	input wire logic rx_bit,
	output logic pulse_n
);
	import smdi_pkg::*;

	logic [5:0] cnt_q;
	logic [5:0] limit_q;
	logic edge_seen_q;
	logic prev_bit_q;
	logic [3:0] ones_q;
	logic pulse_n_q;
	logic hit;
	logic data_edge;
	logic [5:0] quad_int;

	assign hit = (6'(cnt_q + 6'h01) == limit_q);
	assign data_edge = (rx_bit != prev_bit_q);
	assign pulse_n = pulse_n_q;

	// Edge position inside the cell selects the next interval
	always_comb
	begin
		case (cnt_q[4:3])
			2'h0: quad_int = `SMDI_BIT_TIMING_RECOVERY_PULSE_Q1_INT; // R19
			2'h1: quad_int = `SMDI_BIT_TIMING_RECOVERY_PULSE_Q2_INT; // R20
			2'h2: quad_int = `SMDI_BIT_TIMING_RECOVERY_PULSE_Q3_INT; // R19
			default: quad_int = `SMDI_BIT_TIMING_RECOVERY_PULSE_Q4_INT; // R20
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			cnt_q <= 6'h00;
			limit_q <= `SMDI_BIT_TIMING_RECOVERY_PULSE_NOMINAL;
			edge_seen_q <= 1'b0;
			prev_bit_q <= 1'b1;
			ones_q <= 4'h0;
			pulse_n_q <= 1'b1;
		end
		else if (sample_tick)
		begin
			prev_bit_q <= rx_bit;
			pulse_n_q <= !hit; // R17
			if (hit)
			begin
				cnt_q <= 6'h00;
				edge_seen_q <= 1'b0;
				// No edge in the cell keeps the nominal spacing
				limit_q <= `SMDI_BIT_TIMING_RECOVERY_PULSE_NOMINAL; // R18
				if (!rx_bit)
					ones_q <= 4'h0;
				else if (ones_q != `SMDI_BIT_TIMING_RECOVERY_PULSE_IDLE_ONES)
					ones_q <= 4'(ones_q + 4'h1);
			end
			else
			begin
				cnt_q <= 6'(cnt_q + 6'h01);
				// Only the first edge in the cell moves this pulse
				if (data_edge && !edge_seen_q && !cnt_q[5]) // R18
				begin
					edge_seen_q <= 1'b1;
					// Idle line keeps the nominal spacing
					if (ones_q != `SMDI_BIT_TIMING_RECOVERY_PULSE_IDLE_ONES) // R21
						limit_q <= quad_int; // R19
				end
			end
		end
	end

endmodule
`default_nettype wire

/* smdi_top.sv */
// Modem control ports, serial data timing and host transfer logic
//
// Notes on behaviour
// (R01) Select plus strobe moves data without decode
// (R02) Non-DMA mode signals data on interrupt lines
// (R03) Status mirrors interrupts and result-available bits
// (R04) Configuration command picks DMA or non-DMA
// (R05) All modem pins are active low
// (R06) Input bit 0 shows CTS; wait CTS
// (R07) CTS loss aborts frame with failure result
// (R08) Input bit 1 shows CD; loss fails
// (R09) Bits 2-4 user inputs; 5-7 read one
// (R10) Automatic RTS raised, released byte after frame
// (R11) Flag pin pulses on each received flag
// (R12) User outputs 1-4; port readable back
// (R13) Modem outputs go high on reset
// (R14) Transmit on falling, receive on rising edge
// (R15) Data loopback feeds receiver, pin still driven
// (R16) Clock loopback clocks receiver from transmit clock
// (R17) Loop samples at 32x, pulses mid-bit
// (R18) No edge gives next pulse at 32
// (R19) Quadrant one thirty, quadrant three thirty-three
// (R20) Quadrant two thirty-one, quadrant four thirty-four
// (R21) After fifteen ones pulses every thirty-two
// (R22) Sender should use NRZI and preamble; transmitter sends plain NRZ bits, no preamble
`timescale 1ns/1ps
`default_nettype none
`include "smdi_map.svh"
module smdi_top (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cfg_valid,
	input wire logic cfg_dma_mode,
	input wire logic cfg_data_loop,
	input wire logic cfg_clock_loop,
	input wire logic port_cmd_valid,
	input wire smdi_pkg::smdi_port_op_e port_cmd_op,
	input wire logic [7:0] port_cmd_data,
	output logic [7:0] port_result,
	output logic port_result_valid,
	input wire logic tx_cmd_valid,
	input wire logic [7:0] tx_cmd_len,
	input wire logic rx_cmd_valid,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	input wire logic transmit_data_select,
	input wire logic receive_data_select,
	output logic transmit_data_request,
	output logic receive_data_request,
	output logic transmit_service_irq,
	output logic receive_service_irq,
	output logic [3:0] status_bits,
	input wire logic tx_result_rd,
	input wire logic rx_result_rd,
	output logic [7:0] tx_result,
	output logic [7:0] rx_result,
	input wire logic cts_n,
	input wire logic cd_n,
	input wire logic [2:0] user_input_pins_n,
	output logic rts_n,
	output logic flag_detect_n,
	output logic [3:0] user_output_pins_n,
	input wire logic transmit_bit_clock_n,
	input wire logic receive_bit_clock_n,
	input wire logic rxd,
	output logic txd,
	input wire logic sample_clock_x32_n,
	output logic bit_timing_recovery_pulse_n
);
	import smdi_pkg::*;

	// ****************************************************************
	// Pin synchronisers and edge finders
	// ****************************************************************
	logic [8:0] pin_meta_q;
	logic [8:0] pin_sync_q;
	logic [2:0] clk_prev_q;
	logic cts_act;
	logic cd_act;
	logic tx_fall;
	logic tx_rise;
	logic rx_rise;
	logic x32_tick;
	logic rx_bit;
	logic cfg_data_loop_q;
	logic cfg_clock_loop_q;
	logic txd_q;

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			pin_meta_q <= 9'h1FF;
			pin_sync_q <= 9'h1FF;
			clk_prev_q <= 3'h7;
		end
		else
		begin
			pin_meta_q <= {sample_clock_x32_n, transmit_bit_clock_n,
				receive_bit_clock_n, rxd, cts_n, cd_n, user_input_pins_n};
			pin_sync_q <= pin_meta_q;
			clk_prev_q <= pin_sync_q[8:6];
		end
	end

	assign cts_act = !pin_sync_q[4]; // R05
	assign cd_act = !pin_sync_q[3]; // R05
	assign x32_tick = clk_prev_q[2] && !pin_sync_q[8];
	assign tx_fall = clk_prev_q[1] && !pin_sync_q[7]; // R14
	assign tx_rise = !clk_prev_q[1] && pin_sync_q[7];
	// Receive clock may be taken from the transmit clock
	assign rx_rise = cfg_clock_loop_q ? tx_rise : // R16
		(!clk_prev_q[0] && pin_sync_q[6]); // R14
	assign rx_bit = cfg_data_loop_q ? txd_q : pin_sync_q[5]; // R15

	// ****************************************************************
	// Configuration and modem output port
	// ****************************************************************
	logic cfg_dma_q;
	logic [3:0] user_out_q;
	logic [7:0] port_result_q;
	logic port_result_valid_q;
	logic rts_q;
	logic flag_q;
	logic port_wr;

	assign port_wr = port_cmd_valid && port_cmd_op == SMDI_OP_WR_OUT;

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			cfg_dma_q <= 1'b0;
			cfg_data_loop_q <= 1'b0;
			cfg_clock_loop_q <= 1'b0;
		end
		else if (cfg_valid)
		begin
			cfg_dma_q <= cfg_dma_mode; // R04
			cfg_data_loop_q <= cfg_data_loop;
			cfg_clock_loop_q <= cfg_clock_loop;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			user_out_q <= 4'(`SMDI_OUT_RESET >> 1);
			port_result_q <= 8'h00;
			port_result_valid_q <= 1'b0;
		end
		else
		begin
			port_result_valid_q <= port_cmd_valid &&
				port_cmd_op != SMDI_OP_NONE;
			if (port_wr)
				user_out_q <= port_cmd_data[4:1]; // R12
			if (port_cmd_valid && port_cmd_op == SMDI_OP_RD_IN)
				port_result_q <= {`SMDI_IN_UNUSED, // R09
					~pin_sync_q[2:0], cd_act, cts_act}; // R06 R08 R09
			else if (port_cmd_valid && port_cmd_op == SMDI_OP_RD_OUT)
				port_result_q <= {`SMDI_OUT_UNUSED, flag_q, // R11
					user_out_q, rts_q}; // R12
		end
	end

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	smdi_tx_state_e tx_state_q;
	logic [7:0] tx_buf_q;
	logic tx_buf_full_q;
	logic [7:0] tx_load_cnt_q;
	logic [7:0] tx_send_cnt_q;
	logic [7:0] tx_sh_q;
	logic [2:0] tx_bit_q;
	logic rts_auto_q;
	logic tx_ira_q;
	logic [7:0] tx_result_q;
	logic tx_need;

	assign tx_need = (tx_state_q == SMDI_TX_WAIT ||
		tx_state_q == SMDI_TX_SEND) && !tx_buf_full_q &&
		tx_load_cnt_q != 8'h00;

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			tx_state_q <= SMDI_TX_IDLE;
			tx_buf_q <= 8'h00;
			tx_buf_full_q <= 1'b0;
			tx_load_cnt_q <= 8'h00;
			tx_send_cnt_q <= 8'h00;
			tx_sh_q <= 8'hFF;
			tx_bit_q <= 3'h0;
			rts_auto_q <= 1'b0;
			rts_q <= 1'b0; // R13
			txd_q <= 1'b1;
			tx_ira_q <= 1'b0;
			tx_result_q <= `SMDI_RES_OK;
		end
		else
		begin
			if (tx_result_rd)
				tx_ira_q <= 1'b0;
			if (port_wr)
				rts_q <= port_cmd_data[`SMDI_OUT_RTS_BIT];
			case (tx_state_q)
				SMDI_TX_IDLE:
				begin
					if (tx_cmd_valid)
					begin
						tx_load_cnt_q <= tx_cmd_len;
						tx_send_cnt_q <= tx_cmd_len;
						tx_bit_q <= 3'h0;
						rts_auto_q <= !rts_q; // R10
						rts_q <= 1'b1; // R10
						tx_state_q <= SMDI_TX_WAIT;
					end
				end
				SMDI_TX_WAIT:
				begin
					if (cts_act)
						tx_state_q <= SMDI_TX_SEND; // R06
				end
				SMDI_TX_SEND:
				begin
					if (!cts_act)
					begin
						tx_result_q <= `SMDI_RES_CTS_FAIL; // R07
						tx_ira_q <= 1'b1; // R07
						tx_load_cnt_q <= 8'h00;
						tx_buf_full_q <= 1'b0;
						txd_q <= 1'b1;
						tx_bit_q <= 3'h0;
						tx_state_q <= SMDI_TX_TAIL; // R07
					end
					else if (tx_fall && tx_bit_q != 3'h0)
					begin
						txd_q <= tx_sh_q[0]; // R14
						tx_sh_q <= {1'b1, tx_sh_q[7:1]};
						tx_bit_q <= 3'(tx_bit_q - 3'h1);
					end
					else if (tx_fall && tx_send_cnt_q == 8'h00)
					begin
						txd_q <= 1'b1;
						tx_result_q <= `SMDI_RES_OK;
						tx_ira_q <= 1'b1;
						tx_state_q <= SMDI_TX_TAIL;
					end
					else if (tx_fall && tx_buf_full_q)
					begin
						txd_q <= tx_buf_q[0]; // R14
						tx_sh_q <= {1'b1, tx_buf_q[7:1]};
						tx_bit_q <= `SMDI_BYTE_LAST;
						tx_buf_full_q <= 1'b0;
						tx_send_cnt_q <= 8'(tx_send_cnt_q - 8'h01);
					end
					else if (tx_fall)
						txd_q <= 1'b1;
				end
				SMDI_TX_TAIL:
				begin
					// One byte time of idle before dropping RTS
					if (tx_fall)
					begin
						tx_bit_q <= 3'(tx_bit_q + 3'h1);
						if (tx_bit_q == `SMDI_BYTE_LAST)
						begin
							if (rts_auto_q)
								rts_q <= 1'b0; // R10
							tx_state_q <= SMDI_TX_IDLE;
						end
					end
				end
				default:
					tx_state_q <= SMDI_TX_IDLE;
			endcase
			if (transmit_data_select && host_wr && tx_need)
			begin
				tx_buf_q <= host_wdata; // R01
				tx_buf_full_q <= 1'b1; // R01
				tx_load_cnt_q <= 8'(tx_load_cnt_q - 8'h01);
			end
		end
	end

	// ****************************************************************
	// Receiver
	// ****************************************************************
	smdi_rx_state_e rx_state_q;
	logic [7:0] rx_sh_q;
	logic [7:0] rx_buf_q;
	logic rx_buf_full_q;
	logic [2:0] rx_bit_q;
	logic rx_got_q;
	logic rx_ira_q;
	logic [7:0] rx_result_q;
	logic [7:0] host_rdata_q;
	logic [7:0] rx_next;
	logic rx_flag;

	assign rx_next = {rx_bit, rx_sh_q[7:1]};
	assign rx_flag = rx_rise && rx_state_q != SMDI_RX_OFF &&
		rx_next == `SMDI_FLAG_CHAR;

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			rx_state_q <= SMDI_RX_OFF;
			rx_sh_q <= 8'h00;
			rx_buf_q <= 8'h00;
			rx_buf_full_q <= 1'b0;
			rx_bit_q <= 3'h0;
			rx_got_q <= 1'b0;
			rx_ira_q <= 1'b0;
			rx_result_q <= `SMDI_RES_OK;
			host_rdata_q <= 8'h00;
			flag_q <= 1'b0;
		end
		else
		begin
			flag_q <= rx_flag; // R11
			if (rx_rise)
				rx_sh_q <= rx_next; // R14
			if (receive_data_select && host_rd)
			begin
				host_rdata_q <= rx_buf_q; // R01
				rx_buf_full_q <= 1'b0;
			end
			if (rx_result_rd)
				rx_ira_q <= 1'b0;
			case (rx_state_q)
				SMDI_RX_OFF:
				begin
					if (rx_cmd_valid)
						rx_state_q <= SMDI_RX_HUNT;
				end
				SMDI_RX_HUNT:
				begin
					if (rx_flag)
					begin
						rx_bit_q <= 3'h0;
						rx_got_q <= 1'b0;
						rx_state_q <= SMDI_RX_FRAME;
					end
				end
				SMDI_RX_FRAME:
				begin
					// Carrier may drop between frames but not inside
					if (!cd_act)
					begin
						rx_result_q <= `SMDI_RES_CD_FAIL; // R08
						rx_ira_q <= 1'b1; // R08
						rx_state_q <= SMDI_RX_HUNT;
					end
					else if (rx_flag)
					begin
						rx_bit_q <= 3'h0;
						if (rx_got_q)
						begin
							rx_result_q <= `SMDI_RES_OK;
							rx_ira_q <= 1'b1;
							rx_state_q <= SMDI_RX_HUNT;
						end
					end
					else if (rx_rise)
					begin
						rx_bit_q <= 3'(rx_bit_q + 3'h1);
						if (rx_bit_q == `SMDI_BYTE_LAST)
						begin
							rx_buf_q <= rx_next;
							rx_buf_full_q <= 1'b1;
							rx_got_q <= 1'b1;
						end
					end
				end
				default:
					rx_state_q <= SMDI_RX_OFF;
			endcase
		end
	end

	// ****************************************************************
	// Requests, interrupt lines and status mirror
	// ****************************************************************
	logic tx_drq_q;
	logic rx_drq_q;
	logic tx_irq_q;
	logic rx_irq_q;
	logic [3:0] status_q;
	logic tx_irq_w;
	logic rx_irq_w;

	// Non-DMA mode reuses the interrupt line for data service
	assign tx_irq_w = tx_ira_q || (!cfg_dma_q && tx_need); // R02
	assign rx_irq_w = rx_ira_q || (!cfg_dma_q && rx_buf_full_q); // R02

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			tx_drq_q <= 1'b0;
			rx_drq_q <= 1'b0;
			tx_irq_q <= 1'b0;
			rx_irq_q <= 1'b0;
			status_q <= 4'h0;
		end
		else
		begin
			tx_drq_q <= cfg_dma_q && tx_need; // R01 R04
			rx_drq_q <= cfg_dma_q && rx_buf_full_q; // R01 R04
			tx_irq_q <= tx_irq_w;
			rx_irq_q <= rx_irq_w;
			status_q <= {rx_ira_q, rx_irq_w, tx_ira_q, tx_irq_w}; // R03
		end
	end

	// ****************************************************************
	// Bit timing recovery loop
	// ****************************************************************
	smdi_bit_timing_recovery_pulse u_bit_timing_recovery_pulse (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.sample_tick(x32_tick),
		.rx_bit(rx_bit),
		.pulse_n(bit_timing_recovery_pulse_n)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign port_result = port_result_q;
	assign port_result_valid = port_result_valid_q;
	assign host_rdata = host_rdata_q;
	assign transmit_data_request = tx_drq_q;
	assign receive_data_request = rx_drq_q;
	assign transmit_service_irq = tx_irq_q;
	assign receive_service_irq = rx_irq_q;
	assign status_bits = status_q;
	assign tx_result = tx_result_q;
	assign rx_result = rx_result_q;
	assign rts_n = !rts_q; // R05 R13
	assign flag_detect_n = !flag_q; // R05 R13
	assign user_output_pins_n = ~user_out_q; // R05 R13
	assign txd = txd_q;

endmodule
`default_nettype wire

/* smdi_top_monitor.sv */
// Assertion checker on the ports of the modem interface top
`timescale 1ns/1ps
`default_nettype none
module smdi_top_monitor (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cfg_valid,
	input wire logic cfg_dma_mode,
	input wire logic port_cmd_valid,
	input wire smdi_pkg::smdi_port_op_e port_cmd_op,
	input wire logic [7:0] port_cmd_data,
	input wire logic [7:0] port_result,
	input wire logic port_result_valid,
	input wire logic transmit_data_request,
	input wire logic transmit_service_irq,
	input wire logic [3:0] status_bits,
	input wire logic rts_n,
	input wire logic flag_detect_n,
	input wire logic [3:0] user_output_pins_n,
	input wire logic txd,
	input wire logic bit_timing_recovery_pulse_n
);
	import smdi_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// No claim on the mode until the host has configured it
	logic dma_q;
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			dma_q <= 1'b1;
		else if (cfg_valid)
			dma_q <= cfg_dma_mode;
	end
	// ****************************************************************
	// Reset, port command, request line, status and flag checks
	// ****************************************************************
	sequence rd_in_s;
		port_cmd_valid && port_cmd_op == SMDI_OP_RD_IN;
	endsequence
	sequence rd_out_s;
		port_cmd_valid && port_cmd_op == SMDI_OP_RD_OUT;
	endsequence
	sequence wr_out_s;
		port_cmd_valid && port_cmd_op == SMDI_OP_WR_OUT;
	endsequence
	rst_release_a: assert property ($rose(rstn) |-> rts_n && txd
		&& flag_detect_n && bit_timing_recovery_pulse_n
		&& &user_output_pins_n)
		else $error("modem outputs low after reset");
	port_answer_a: assert property (port_cmd_valid
		&& port_cmd_op != SMDI_OP_NONE |=> port_result_valid)
		else $error("port command not answered");
	port_refuse_a: assert property (!port_cmd_valid
		|| port_cmd_op == SMDI_OP_NONE |=> !port_result_valid)
		else $error("port answer without command");
	input_unused_a: assert property (rd_in_s |=> port_result[7:5] == 3'h7)
		else $error("unused input bits not one");
	output_unused_a: assert property (rd_out_s |=> !port_result[7:6])
		else $error("unused output bits not zero");
	out_readback_a: assert property (rd_out_s |=>
		port_result[4:0] == ~{user_output_pins_n, rts_n})
		else $error("output port readback differs from pins");
	write_user_a: assert property (wr_out_s |=>
		user_output_pins_n == ~$past(port_cmd_data[4:1]))
		else $error("user output pins not written");
	drq_nondma_a: assert property (!dma_q |-> !transmit_data_request)
		else $error("data request line used in non-DMA mode");
	status_mirror_a: assert property (status_bits[0] == transmit_service_irq)
		else $error("status does not mirror transmit interrupt");
	flag_pulse_a: assert property ($fell(flag_detect_n) |=> flag_detect_n)
		else $error("flag pulse longer than one cycle");
endmodule
`default_nettype wire

/* smdi_modem_model.sv */
// Modem partner: answers request-to-send, supplies the transmit clock
`timescale 1ns/1ps
`default_nettype none
module smdi_modem_model (
	input wire logic rts_n,
	input wire logic drop_cts,
	output logic cts_n,
	output logic transmit_bit_clock_n
);
	initial
	begin
		cts_n = 1'b1;
		transmit_bit_clock_n = 1'b1;
	end
	// Turnaround delay, so the block really has to wait for it
	always @(rts_n or drop_cts)
		cts_n <= #500 rts_n | drop_cts;
	// Clock stands high while the modem is not keyed
	always
	begin
		#100;
		transmit_bit_clock_n = rts_n ? 1'b1 : ~transmit_bit_clock_n;
	end
endmodule
`default_nettype wire

/* sdlc_modem_interface_bit_timing_recovery_pulse_tb.sv */
// Self-checking bench of the modem interface block
`timescale 1ns/1ps
`default_nettype none
module sdlc_modem_interface_bit_timing_recovery_pulse_tb;
	import smdi_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic cfg_valid = 1'b0, cfg_dma_mode = 1'b0, cfg_data_loop = 1'b0;
	logic cfg_clock_loop = 1'b0, port_cmd_valid = 1'b0, div = 1'b0;
	smdi_port_op_e port_cmd_op = SMDI_OP_NONE;
	logic [7:0] port_cmd_data = 8'h00, tx_cmd_len = 8'h00;
	logic [7:0] host_wdata = 8'h00;
	logic tx_cmd_valid = 1'b0, rx_cmd_valid = 1'b0, host_wr = 1'b0;
	logic transmit_data_select = 1'b0, tx_result_rd = 1'b0, cd_n = 1'b1;
	logic host_rd = 1'b0, receive_data_select = 1'b0;
	logic [2:0] user_input_pins_n = 3'h7;
	logic rxd = 1'b1, sample_clock_x32_n = 1'b1, drop_cts = 1'b0;
	logic cts_n, transmit_bit_clock_n, rts_n, flag_detect_n, txd;
	logic port_result_valid, transmit_data_request, transmit_service_irq;
	logic bit_timing_recovery_pulse_n;
	logic receive_data_request, receive_service_irq;
	logic [7:0] host_rdata, rx_result;
	logic [7:0] port_result, tx_result, r, idle_pins;
	logic [3:0] status_bits, user_output_pins_n;
	int n_mismatch = 0, n_checks = 0, n_flag = 0;
	int tick_total = 0, last_tick = 0, t;
	assign idle_pins = {rts_n, flag_detect_n, txd,
		bit_timing_recovery_pulse_n, user_output_pins_n};
	smdi_top i_smdi_top (
		.clk_sys, .rstn, .cfg_valid, .cfg_dma_mode, .cfg_data_loop,
		.cfg_clock_loop, .port_cmd_valid, .port_cmd_op, .port_cmd_data,
		.port_result, .port_result_valid, .tx_cmd_valid, .tx_cmd_len,
		.rx_cmd_valid, .host_wr, .host_rd, .host_wdata,
		.host_rdata, .transmit_data_select, .receive_data_select,
		.transmit_data_request, .receive_data_request,
		.transmit_service_irq, .receive_service_irq, .status_bits,
		.tx_result_rd, .rx_result_rd(1'b0), .tx_result, .rx_result,
		.cts_n, .cd_n, .user_input_pins_n, .rts_n, .flag_detect_n,
		.user_output_pins_n, .transmit_bit_clock_n,
		.receive_bit_clock_n(1'b1), .rxd, .txd, .sample_clock_x32_n,
		.bit_timing_recovery_pulse_n
	);
	smdi_modem_model i_smdi_modem_model (
		.rts_n, .drop_cts, .cts_n, .transmit_bit_clock_n
	);
	always #12.5 clk_sys = ~clk_sys;
	// ****************************************************************
	// Sample clock at four system cycles, flag pulse counter
	// ****************************************************************
	always @(posedge clk_sys)
	begin
		div <= ~div;
		if (div)
		begin
			sample_clock_x32_n <= ~sample_clock_x32_n;
			if (sample_clock_x32_n)
				tick_total <= tick_total + 1;
		end
		if (flag_detect_n === 1'b0)
			n_flag <= n_flag + 1;
	end
	task check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task conclude();
		if (n_mismatch == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task port_cmd(input smdi_port_op_e op, input logic [7:0] d);
		@(posedge clk_sys);
		port_cmd_valid <= 1'b1;
		port_cmd_op <= op;
		port_cmd_data <= d;
		@(posedge clk_sys);
		port_cmd_valid <= 1'b0;
		#1;
		r = port_result;
	endtask
	task cfg(input logic dma, input logic loop_on);
		@(posedge clk_sys);
		cfg_valid <= 1'b1;
		cfg_dma_mode <= dma;
		cfg_data_loop <= loop_on;
		cfg_clock_loop <= loop_on;
		@(posedge clk_sys);
		cfg_valid <= 1'b0;
	endtask
	task tx_start(input logic [7:0] len);
		@(posedge clk_sys);
		tx_cmd_valid <= 1'b1;
		tx_cmd_len <= len;
		@(posedge clk_sys);
		tx_cmd_valid <= 1'b0;
	endtask
	task wait_ira();
		for (int i = 0; i < 2000 && status_bits[1] !== 1'b1; i++)
			@(posedge clk_sys);
		#1;
	endtask
	// Ticks between the last two recovery pulses
	task wait_pulse(output int n);
		for (int i = 0; i < 20 && bit_timing_recovery_pulse_n !== 1'b1; i++)
			@(posedge clk_sys);
		for (int i = 0; i < 400 && bit_timing_recovery_pulse_n !== 1'b0; i++)
			@(posedge clk_sys);
		n = tick_total - last_tick;
		last_tick = tick_total;
	endtask
	task tx_write(input logic [7:0] d);
		for (int i = 0; i < 400 && transmit_data_request !== 1'b1; i++)
			@(posedge clk_sys);
		@(posedge clk_sys);
		transmit_data_select <= 1'b1;
		host_wr <= 1'b1;
		host_wdata <= d;
		@(posedge clk_sys);
		transmit_data_select <= 1'b0;
		host_wr <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	task t_ports();
		port_cmd(SMDI_OP_WR_OUT, 8'hEB);
		check({4'h0, user_output_pins_n}, 8'h0A);
		port_cmd(SMDI_OP_RD_OUT, 8'h00);
		check(r, 8'h0B);
		cd_n <= 1'b0;
		user_input_pins_n <= 3'h6;
		repeat (40) @(posedge clk_sys);
		port_cmd(SMDI_OP_RD_IN, 8'h00);
		check(r, 8'hE7);
		port_cmd(SMDI_OP_WR_OUT, 8'h00);
		cd_n <= 1'b1;
		user_input_pins_n <= 3'h3;
		repeat (40) @(posedge clk_sys);
		port_cmd(SMDI_OP_RD_IN, 8'h00);
		check(r, 8'hF0);
		port_cmd(SMDI_OP_NONE, 8'h00);
	endtask
	task t_bit_timing_recovery_pulse();
		int k[4] = '{3, 11, 19, 27};
		int e[4] = '{30, 31, 33, 34};
		int s;
		wait_pulse(t);
		for (int i = 0; i < 17; i++)
		begin
			wait_pulse(t);
			check(8'(t), 8'h20);
		end
		s = tick_total;
		for (int i = 0; i < 400 && tick_total - s < 11; i++)
			@(posedge clk_sys);
		rxd <= 1'b0;
		wait_pulse(t);
		check(8'(t), 8'h20);
		for (int q = 0; q < 4; q++)
		begin
			wait_pulse(t);
			s = tick_total;
			for (int i = 0; i < 400 && tick_total - s < k[q]; i++)
				@(posedge clk_sys);
			rxd <= ~rxd;
			wait_pulse(t);
			check(8'(t), 8'(e[q]));
		end
	endtask
	task t_tx_dma();
		int n0;
		cfg(1'b1, 1'b1);
		@(posedge clk_sys);
		cd_n <= 1'b0;
		rx_cmd_valid <= 1'b1;
		@(posedge clk_sys);
		rx_cmd_valid <= 1'b0;
		tx_start(8'h03);
		repeat (2) @(posedge clk_sys);
		#1;
		check({7'h0, rts_n}, 8'h00);
		for (int i = 0; i < 400 && transmit_data_request !== 1'b1; i++)
			@(posedge clk_sys);
		check({7'h0, transmit_service_irq}, 8'h00);
		n0 = n_flag;
		@(posedge clk_sys);
		transmit_data_select <= 1'b1;
		host_wr <= 1'b1;
		host_wdata <= 8'h7E;
		@(posedge clk_sys);
		transmit_data_select <= 1'b0;
		host_wr <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		check({7'h0, transmit_data_request}, 8'h00);
		tx_write(8'hA5);
		tx_write(8'h7E);
		wait_ira();
		check(tx_result, 8'h00);
		check({7'h0, rts_n}, 8'h00);
		for (int i = 0; i < 400 && rts_n !== 1'b1; i++)
			@(posedge clk_sys);
		check({7'h0, rts_n}, 8'h01);
		check(8'(n_flag - n0), 8'h02);
		check({6'h0, receive_data_request, receive_service_irq}, 8'h03);
		@(posedge clk_sys);
		receive_data_select <= 1'b1;
		host_rd <= 1'b1;
		@(posedge clk_sys);
		receive_data_select <= 1'b0;
		host_rd <= 1'b0;
		#1;
		check(host_rdata, 8'hA5);
		check(rx_result, 8'h00);
		@(posedge clk_sys);
		tx_result_rd <= 1'b1;
		@(posedge clk_sys);
		tx_result_rd <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check({6'h0, status_bits[1:0]}, 8'h00);
	endtask
	task t_tx_cts();
		cfg(1'b0, 1'b1);
		port_cmd(SMDI_OP_WR_OUT, 8'h01);
		repeat (40) @(posedge clk_sys);
		tx_start(8'h02);
		for (int i = 0; i < 400 && transmit_service_irq !== 1'b1; i++)
			@(posedge clk_sys);
		#1;
		check({transmit_data_request, 5'h0, status_bits[1:0]}, 8'h01);
		@(posedge clk_sys);
		drop_cts <= 1'b1;
		wait_ira();
		check(tx_result, 8'h01);
		drop_cts <= 1'b0;
		repeat (200) @(posedge clk_sys);
		check({7'h0, rts_n}, 8'h00);
		port_cmd(SMDI_OP_WR_OUT, 8'h00);
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		#1;
		check(idle_pins, 8'hFF);
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		#1;
		check(idle_pins, 8'hFF);
		t_ports();
		t_bit_timing_recovery_pulse();
		t_tx_dma();
		t_tx_cts();
		conclude();
	end
	initial
	begin
		#400000;
		n_mismatch++;
		conclude();
	end
endmodule
bind smdi_top smdi_top_monitor i_smdi_top_monitor (
	.clk_sys, .rstn, .cfg_valid, .cfg_dma_mode, .port_cmd_valid,
	.port_cmd_op, .port_cmd_data, .port_result, .port_result_valid,
	.transmit_data_request, .transmit_service_irq, .status_bits, .rts_n,
	.flag_detect_n, .user_output_pins_n, .txd, .bit_timing_recovery_pulse_n
);
`default_nettype wire
